/* uls_pkg.sv */
// Package: constants, field layouts and types of the line status and modem control block.
`default_nettype none

package uls_pkg;

  // ****************************************************************
  // Register map, byte addresses on the APB
  // ****************************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_DATA      = 8'h00;
  localparam logic [7:0]  OFS_MODEM_CTL = 8'h04;
  localparam logic [7:0]  OFS_LINE_STS  = 8'h08;
  localparam logic [7:0]  OFS_CTRL      = 8'h0c;
  localparam logic [7:0]  OFS_INT_STS   = 8'h10;
  localparam logic [7:0]  OFS_INT_MASK  = 8'h14;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned MDC_DTR       = 0;
  localparam int unsigned MDC_RTS       = 1;
  localparam int unsigned MDC_W         = 5;
  localparam logic [4:0]  MDC_RST       = 5'h00;
  localparam int unsigned LNS_RDR       = 0;
  localparam int unsigned LNS_OVR       = 1;
  localparam int unsigned LNS_PAR       = 2;
  localparam int unsigned LNS_BRK       = 4;
  localparam int unsigned LNS_THRE      = 5;
  localparam int unsigned LNS_TEMT      = 6;
  localparam int unsigned LNS_FERR      = 7;
  localparam int unsigned CTRL_FIFO_EN  = 0;
  localparam int unsigned INT_THRE      = 0;
  localparam int unsigned INT_RDR       = 1;
  localparam int unsigned INT_OVR       = 2;
  localparam int unsigned INT_LERR      = 3;
  localparam int unsigned INT_W         = 4;
  localparam logic [3:0]  INT_RST       = 4'h0;
  localparam int unsigned BYTE_W        = 8;

  // ****************************************************************
  // Receive FIFO geometry
  // ****************************************************************
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned PTR_W         = 4;
  localparam int unsigned CNT_W         = 5;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;
  localparam logic [4:0]  CNT_ONE       = 5'h01;
  localparam logic [4:0]  CNT_FULL      = 5'h10;
  localparam logic [3:0]  PTR_ONE       = 4'h1;

  // Error flags that travel with each received character.
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } uls_rx_flags_t;

  // Usable depth: one entry in character mode, the whole FIFO otherwise.
  function automatic logic [4:0] uls_depth(input logic fifo_en);
    uls_depth = fifo_en ? CNT_FULL : CNT_ONE;
  endfunction

endpackage

`default_nettype wire

/* uls_rx_flag_fifo.sv */
// Module: per-character error flag store kept in step with the receive FIFO.
`default_nettype none
`timescale 1ns/1ps

module uls_rx_flag_fifo (
  // Clock and reset
  input  wire  logic                  pclk,
  input  wire  logic                  presetn,
  input  wire  logic                  ce,
  // Control
  input  wire  logic                  fifo_en,
  input  wire  logic                  push,
  input  wire  uls_pkg::uls_rx_flags_t push_flags,
  input  wire  logic                  pop,
  // State
  output logic                        not_empty,
  output logic                        full,
  output logic                        err_any,
  output uls_pkg::uls_rx_flags_t      top_flags
);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  uls_pkg::uls_rx_flags_t          mem_ff [uls_pkg::FIFO_DEPTH];
  logic [uls_pkg::PTR_W-1:0]       wr_ptr_ff;
  logic [uls_pkg::PTR_W-1:0]       rd_ptr_ff;
  logic [uls_pkg::CNT_W-1:0]       cnt_ff;
  logic [uls_pkg::CNT_W-1:0]       err_cnt_ff;
  logic [uls_pkg::CNT_W-1:0]       nxt_cnt;
  logic [uls_pkg::CNT_W-1:0]       nxt_err_cnt;
  wire                             do_push;
  wire                             do_pop;
  wire                             push_err;
  wire                             pop_err;

  assign not_empty   = (cnt_ff != uls_pkg::CNT_ZERO);
  assign full        = (cnt_ff >= uls_pkg::uls_depth(fifo_en));
  assign do_push     = push && !full;
  assign do_pop      = pop && not_empty;
  assign top_flags   = mem_ff[rd_ptr_ff];
  assign push_err    = do_push && (|push_flags);
  assign pop_err     = do_pop && (|top_flags);
  // A count of errored entries lets the summary clear by itself once the last one leaves.
  assign err_any     = (err_cnt_ff != uls_pkg::CNT_ZERO);
  assign nxt_cnt     = cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
  assign nxt_err_cnt = err_cnt_ff + {4'h0, push_err} - {4'h0, pop_err};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      cnt_ff     <= uls_pkg::CNT_ZERO;
      err_cnt_ff <= uls_pkg::CNT_ZERO;
    end else if (ce) begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + uls_pkg::PTR_ONE;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + uls_pkg::PTR_ONE;
      end
      cnt_ff     <= nxt_cnt;
      err_cnt_ff <= nxt_err_cnt;
    end
  end

  // Data array has no reset; entries are only read once written.
  always_ff @(posedge pclk) begin
    if (ce && do_push) begin
      mem_ff[wr_ptr_ff] <= push_flags;
    end
  end

endmodule

`default_nettype wire

/* uls_line_modem.sv */
// Module: APB register block for modem control and line status of one serial channel.
//
// Local design decisions: the placing of the registers and the APB register port.
`default_nettype none
`timescale 1ns/1ps

// Functional notes
// - Request-to-send control bit one drives the active-low request pin low.
// - Terminal-ready control bit zero, the default, holds the active-low ready pin high.
// - Terminal-ready control bit one drives the active-low ready pin low.
// - Error summary reads one while any FIFO character has parity, framing or break.
// - Error summary clears itself once no remaining character carries an error.
// - Character mode: transmitter empty is one when holding and shift register both empty.
// - Transmitter empty drops as soon as holding or shift register has a character.
// - FIFO mode: transmitter empty is one when transmit FIFO and shift register empty.
// - Character mode: holding empty sets when a character moves into the shift register.
// - Character mode: holding empty clears with the CPU write to the holding register.
// - With its enable set, holding empty raises the channel interrupt request.
// - FIFO mode: holding empty sets when FIFO empties, clears on a byte written.
// - Data ready reads one while any received character waits, otherwise zero.
// - Character arriving into a full FIFO sets overrun and is not stored.
// - A break sets the break flag; FIFO mode stores only one break character.
module uls_line_modem (
  // Clock, reset, enable
  input  wire  logic                        pclk,
  input  wire  logic                        presetn,
  input  wire  logic                        ce,
  // APB slave
  input  wire  logic                        psel,
  input  wire  logic                        penable,
  input  wire  logic                        pwrite,
  input  wire  logic [uls_pkg::ADDR_W-1:0]  paddr,
  input  wire  logic [31:0]                 pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Transmitter side
  output logic                              tx_wr,
  output logic [uls_pkg::BYTE_W-1:0]        tx_data,
  input  wire  logic                        tx_load,
  input  wire  logic                        shf_empty,
  // Receiver side
  input  wire  logic                        rx_char_done,
  input  wire  uls_pkg::uls_rx_flags_t      rx_flags,
  input  wire  logic                        rx_line_idle,
  input  wire  logic [uls_pkg::BYTE_W-1:0]  rx_data,
  output logic                              rx_pop,
  // Modem, mode and interrupt
  output logic                              rts_n,
  output logic                              dtr_n,
  output logic                              fifo_mode,
  output logic                              irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0]                     prdata_ff;
  logic                            pready_ff;
  logic                            pslverr_ff;
  logic                            tx_wr_ff;
  logic [uls_pkg::BYTE_W-1:0]      tx_data_ff;
  logic                            rx_pop_ff;
  logic                            rts_n_ff;
  logic                            dtr_n_ff;
  logic                            irq_ff;
  logic [uls_pkg::MDC_W-1:0]       mdc_ff;
  logic                            fifo_en_ff;
  logic [uls_pkg::CNT_W-1:0]       tx_level_ff;
  logic                            ovr_ff;
  logic                            brk_hold_ff;
  logic [uls_pkg::INT_W-1:0]       int_sts_ff;
  logic [uls_pkg::INT_W-1:0]       int_mask_ff;
  logic [uls_pkg::CNT_W-1:0]       nxt_tx_level;
  logic [uls_pkg::INT_W-1:0]       nxt_int_sts;
  logic                            nxt_ovr;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire                             acc_wait  = psel && penable && !pready_ff;
  wire                             acc_done  = psel && penable && pready_ff;
  wire                             wr_done   = acc_done && pwrite;
  wire                             rd_done   = acc_done && !pwrite;
  wire                             sel_data  = (paddr == uls_pkg::OFS_DATA);
  wire                             sel_mdc   = (paddr == uls_pkg::OFS_MODEM_CTL);
  wire                             sel_lns   = (paddr == uls_pkg::OFS_LINE_STS);
  wire                             sel_ctrl  = (paddr == uls_pkg::OFS_CTRL);
  wire                             sel_ists  = (paddr == uls_pkg::OFS_INT_STS);
  wire                             sel_imask = (paddr == uls_pkg::OFS_INT_MASK);
  wire                             mapped    = sel_data | sel_mdc | sel_lns | sel_ctrl |
                                               sel_ists | sel_imask;
  // Status is read-only; a write to it is refused with an error.
  wire                             bad       = !mapped || (pwrite && sel_lns);

  // ****************************************************************
  // Transmit holding path
  // ****************************************************************
  wire [uls_pkg::CNT_W-1:0]        tx_depth  = uls_pkg::uls_depth(fifo_en_ff);
  wire                             tx_room   = (tx_level_ff < tx_depth);
  // A write into a full holding path is dropped; the data are lost, not queued.
  wire                             tx_push   = wr_done && sel_data && tx_room;
  wire                             tx_move   = tx_load && (tx_level_ff != uls_pkg::CNT_ZERO);
  // Empty flags follow the level that this cycle's write and move produce.
  wire                             thre      = (nxt_tx_level == uls_pkg::CNT_ZERO);
  wire                             temt      = thre && shf_empty;

  assign nxt_tx_level = tx_level_ff + {4'h0, tx_push} - {4'h0, tx_move};

  // ****************************************************************
  // Receive path
  // ****************************************************************
  wire                             rx_not_empty;
  wire                             rx_full;
  wire                             rx_err_any;
  uls_pkg::uls_rx_flags_t          rx_top;
  wire                             brk_repeat = rx_flags.brk && fifo_en_ff && brk_hold_ff;
  wire                             rx_take    = rx_char_done && !brk_repeat;
  wire                             rx_overrun = rx_take && rx_full;
  wire                             rx_store   = rx_take && !rx_full;
  wire                             rx_read    = rd_done && sel_data && rx_not_empty;
  wire                             lns_read   = rd_done && sel_lns;
  wire                             rx_err_in  = rx_store && (|rx_flags);

  assign nxt_ovr = rx_overrun || (ovr_ff && !lns_read);

  uls_rx_flag_fifo u_rx_flags (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .fifo_en    (fifo_en_ff),
    .push       (rx_store),
    .push_flags (rx_flags),
    .pop        (rx_read),
    .not_empty  (rx_not_empty),
    .full       (rx_full),
    .err_any    (rx_err_any),
    .top_flags  (rx_top)
  );

  // ****************************************************************
  // Line status and read mux
  // ****************************************************************
  logic [uls_pkg::BYTE_W-1:0]      lns_val;
  logic [uls_pkg::INT_W-1:0]       int_set;
  logic [31:0]                     rd_mux;

  always_comb begin
    lns_val                             = '0;
    lns_val[uls_pkg::LNS_FERR]          = rx_err_any;
    lns_val[uls_pkg::LNS_TEMT]          = temt;
    lns_val[uls_pkg::LNS_THRE]          = thre;
    lns_val[uls_pkg::LNS_BRK -: 3]      = rx_not_empty ? rx_top : '0;
    lns_val[uls_pkg::LNS_OVR]           = ovr_ff;
    lns_val[uls_pkg::LNS_RDR]           = rx_not_empty;
  end

  always_comb begin
    rd_mux = '0;
    if (sel_data) begin
      rd_mux[uls_pkg::BYTE_W-1:0] = rx_data;
    end else if (sel_mdc) begin
      rd_mux[uls_pkg::MDC_W-1:0] = mdc_ff;
    end else if (sel_lns) begin
      rd_mux[uls_pkg::BYTE_W-1:0] = lns_val;
    end else if (sel_ctrl) begin
      rd_mux[uls_pkg::CTRL_FIFO_EN] = fifo_en_ff;
    end else if (sel_ists) begin
      rd_mux[uls_pkg::INT_W-1:0] = int_sts_ff;
    end else if (sel_imask) begin
      rd_mux[uls_pkg::INT_W-1:0] = int_mask_ff;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  wire [uls_pkg::INT_W-1:0]        w1c = (wr_done && sel_ists) ? pwdata[uls_pkg::INT_W-1:0] : '0;

  always_comb begin
    int_set                    = '0;
    int_set[uls_pkg::INT_THRE] = thre;
    int_set[uls_pkg::INT_RDR]  = rx_store;
    int_set[uls_pkg::INT_OVR]  = rx_overrun;
    int_set[uls_pkg::INT_LERR] = rx_err_in;
  end

  // Set wins over the software clear so an event in the clearing cycle survives.
  assign nxt_int_sts = (int_sts_ff & ~w1c) | int_set;

  // ****************************************************************
  // Bus and register flops
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (ce) begin
      pready_ff  <= acc_wait;
      pslverr_ff <= acc_wait && bad;
      if (acc_wait) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_ff      <= uls_pkg::MDC_RST;
      fifo_en_ff  <= 1'b0;
      int_mask_ff <= uls_pkg::INT_RST;
    end else if (ce && wr_done) begin
      if (sel_mdc) begin
        mdc_ff <= pwdata[uls_pkg::MDC_W-1:0];
      end
      if (sel_ctrl) begin
        fifo_en_ff <= pwdata[uls_pkg::CTRL_FIFO_EN];
      end
      if (sel_imask) begin
        int_mask_ff <= pwdata[uls_pkg::INT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
    end else if (ce) begin
      rts_n_ff <= !mdc_ff[uls_pkg::MDC_RTS];
      dtr_n_ff <= !mdc_ff[uls_pkg::MDC_DTR];
    end
  end

  // ****************************************************************
  // Datapath flops
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_level_ff <= uls_pkg::CNT_ZERO;
      tx_wr_ff    <= 1'b0;
      tx_data_ff  <= '0;
      rx_pop_ff   <= 1'b0;
      ovr_ff      <= 1'b0;
      brk_hold_ff <= 1'b0;
      int_sts_ff  <= uls_pkg::INT_RST;
      irq_ff      <= 1'b0;
    end else if (ce) begin
      tx_level_ff <= nxt_tx_level;
      tx_wr_ff    <= tx_push;
      if (tx_push) begin
        tx_data_ff <= pwdata[uls_pkg::BYTE_W-1:0];
      end
      rx_pop_ff   <= rx_read;
      ovr_ff      <= nxt_ovr;
      // In FIFO mode, one stored break blocks further ones until the line goes idle again.
      brk_hold_ff <= (brk_hold_ff || (rx_take && rx_flags.brk)) && !rx_line_idle;
      int_sts_ff  <= nxt_int_sts;
      irq_ff      <= |(nxt_int_sts & int_mask_ff);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign tx_wr     = tx_wr_ff;
  assign tx_data   = tx_data_ff;
  assign rx_pop    = rx_pop_ff;
  assign rts_n     = rts_n_ff;
  assign dtr_n     = dtr_n_ff;
  assign fifo_mode = fifo_en_ff;
  assign irq       = irq_ff;

endmodule

`default_nettype wire

/* uls_line_modem_properties.sv */
// Checker: port-level properties of the line status and modem control block.
`timescale 1ns/1ps
`default_nettype none

module uls_line_modem_chk (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // Bus and block outputs
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [uls_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       tx_wr,
  input wire logic [7:0]                 tx_data,
  input wire logic                       rx_pop,
  input wire logic                       rts_n,
  input wire logic                       dtr_n,
  input wire logic                       irq
);
  // ****************************************************************
  // Decoded transfers
  // ****************************************************************
  wire       acc    = psel && penable && pready;
  wire       wr_mdc = acc && pwrite && paddr == uls_pkg::OFS_MODEM_CTL;
  wire       wr_dat = acc && pwrite && paddr == uls_pkg::OFS_DATA;
  wire       rd_dat = acc && !pwrite && paddr == uls_pkg::OFS_DATA;
  wire       rd_lns = acc && !pwrite && paddr == uls_pkg::OFS_LINE_STS;
  wire       wr_lns = acc && pwrite && paddr == uls_pkg::OFS_LINE_STS;
  wire       rts_b  = pwdata[uls_pkg::MDC_RTS];
  wire       dtr_b  = pwdata[uls_pkg::MDC_DTR];
  wire [7:0] wlow   = pwdata[7:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rts; wr_mdc |-> ##2 (rts_n == !$past(rts_b, 2)); endproperty
  property p_dtr; wr_mdc |-> ##2 (dtr_n == !$past(dtr_b, 2)); endproperty
  property p_rdy; (psel && !penable) |-> !pready ##1 !pready ##1 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_ro; wr_lns |-> pslverr; endproperty
  property p_txwr; tx_wr |-> $past(wr_dat) && tx_data == $past(wlow); endproperty
  property p_pop; rx_pop |-> $past(rd_dat); endproperty
  property p_lns;
    rd_lns |-> prdata[31:8] == 24'h0 && !(prdata[6] && !prdata[5]) && !(prdata[7] && !prdata[0]);
  endproperty
  property p_irq_hold; (irq && !acc && !$past(acc)) |=> irq; endproperty

  a_rts: assert property (p_rts) else $error("rts_n does not follow the control write");
  a_dtr: assert property (p_dtr) else $error("dtr_n does not follow the control write");
  a_rdy: assert property (p_rdy) else $error("pready not two cycles after setup");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_ro: assert property (p_ro) else $error("line status write not refused");
  a_txwr: assert property (p_txwr) else $error("tx_wr without matching data write");
  a_pop: assert property (p_pop) else $error("rx_pop without data read");
  a_lns: assert property (p_lns) else $error("line status bits inconsistent");
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell with no bus write");

  c_mdc: cover property (wr_mdc);
  c_pop: cover property (rx_pop);
  c_irq: cover property (irq);
endmodule

bind uls_line_modem uls_line_modem_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_wr(tx_wr), .tx_data(tx_data), .rx_pop(rx_pop), .rts_n(rts_n), .dtr_n(dtr_n),
  .irq(irq)
);

`default_nettype wire

/* uls_far_model.sv */
// Far-side model: transmit shift stage and receive character source.
`timescale 1ns/1ps
`default_nettype none

module uls_far_model #(
  parameter int SHIFT_CYC = 40
) (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // From the block and the bench
  input  wire logic            tx_wr,
  input  wire logic            rx_pop,
  input  wire logic            fifo_mode,
  input  wire logic            tx_run,
  // To the block
  output logic                 tx_load,
  output logic                 shf_empty,
  output logic                 rx_char_done,
  output uls_pkg::uls_rx_flags_t rx_flags,
  output logic                 rx_line_idle,
  output logic [7:0]           rx_data
);
  int         pend;
  int         cnt;
  logic       hold;
  logic [7:0] rx_byte;
  logic [7:0] last;
  logic [7:0] q[$];

  initial begin
    rx_char_done = 1'b0;
    rx_flags = 3'h0;
    rx_line_idle = 1'b1;
    rx_byte = 8'h00;
    last = 8'h00;
  end

  // Pending count lags the block's own level by a cycle, so a load is never early.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend = 0;
      cnt = 0;
      hold = 1'b0;
      q.delete();
      tx_load <= 1'b0;
      shf_empty <= 1'b1;
      rx_data <= 8'h00;
    end else begin
      pend = pend + (tx_wr ? 1 : 0) - (tx_load ? 1 : 0);
      tx_load <= 1'b0;
      if (cnt > 0) begin
        cnt = cnt - 1;
        if (cnt == 0) shf_empty <= 1'b1;
      end else if (tx_run && pend > 0) begin
        tx_load <= 1'b1;
        shf_empty <= 1'b0;
        cnt = SHIFT_CYC;
      end
      if (rx_pop && q.size() > 0) begin
        last = q[0];
        void'(q.pop_front());
      end
      if (rx_char_done && q.size() < (fifo_mode ? 16 : 1) && !(fifo_mode && rx_flags.brk && hold)) begin
        q.push_back(rx_byte);
        hold = hold | rx_flags.brk;
      end
      if (rx_line_idle) hold = 1'b0;
      rx_data <= (q.size() > 0) ? q[0] : ~last;
    end
  end

  task automatic send(input logic [7:0] d, input logic [2:0] f);
    @(posedge pclk);
    rx_char_done <= 1'b1;
    rx_flags <= f;
    rx_byte <= d;
    @(posedge pclk);
    rx_char_done <= 1'b0;
    rx_flags <= ~f;
    rx_byte <= ~d;
  endtask

  task automatic line(input logic v);
    @(posedge pclk);
    rx_line_idle <= v;
  endtask
endmodule

`default_nettype wire

/* testbench.sv */
// Testbench: line status and modem control block with its far-side model.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [7:0] A_DT = uls_pkg::OFS_DATA;
  localparam logic [7:0] A_MC = uls_pkg::OFS_MODEM_CTL;
  localparam logic [7:0] A_LS = uls_pkg::OFS_LINE_STS;
  localparam logic [7:0] A_CT = uls_pkg::OFS_CTRL;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, tx_data, rx_data;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, tx_wr, tx_load, shf_empty, rx_char_done, rx_line_idle, rx_pop;
  logic rts_n, dtr_n, fifo_mode, irq, e, tx_run = 1'b1;
  uls_pkg::uls_rx_flags_t rx_flags;
  int error_cnt = 0, n_tests = 0, n_txwr = 0, n0;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (tx_wr === 1'b1) n_txwr <= n_txwr + 1;

  uls_line_modem u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_wr(tx_wr), .tx_data(tx_data), .tx_load(tx_load),
    .shf_empty(shf_empty), .rx_char_done(rx_char_done), .rx_flags(rx_flags),
    .rx_line_idle(rx_line_idle), .rx_data(rx_data), .rx_pop(rx_pop), .rts_n(rts_n),
    .dtr_n(dtr_n), .fifo_mode(fifo_mode), .irq(irq));
  uls_far_model u_far (.pclk(pclk), .presetn(presetn), .tx_wr(tx_wr), .rx_pop(rx_pop),
    .fifo_mode(fifo_mode), .tx_run(tx_run), .tx_load(tx_load), .shf_empty(shf_empty),
    .rx_char_done(rx_char_done), .rx_flags(rx_flags), .rx_line_idle(rx_line_idle),
    .rx_data(rx_data));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the whole request until pready is sampled high; the count checks the latency.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h2);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ls(input logic [31:0] exp);
    apb(1'b0, A_LS, 32'h0);
    chk(r, exp);
  endtask

  task automatic t_modem;
    chk(32'({rts_n, dtr_n, irq}), 32'h6);
    ls(32'h60);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_MC, (i == 4) ? 32'hff : 32'(i));
      repeat (2) @(negedge pclk);
      chk(32'({rts_n, dtr_n}), 32'((i == 4) ? 0 : 3 - i));
      apb(1'b0, A_MC, 32'h0);
      chk(r, (i == 4) ? 32'h1f : 32'(i));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, A_LS, 32'h0);
    ls(32'h60);
  endtask

  task automatic t_tx_char;
    tx_run <= 1'b0;
    n0 = n_txwr;
    apb(1'b1, A_DT, 32'ha5);
    ls(32'h00);
    apb(1'b1, A_DT, 32'h3c);
    chk(32'(n_txwr - n0), 32'h1);
    chk(32'(tx_data), 32'ha5);
    tx_run <= 1'b1;
    repeat (4) @(posedge pclk);
    ls(32'h20);
    repeat (50) @(posedge pclk);
    ls(32'h60);
  endtask

  task automatic t_irq;
    tx_run <= 1'b0;
    apb(1'b1, uls_pkg::OFS_INT_MASK, 32'h1);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, A_DT, 32'h11);
    apb(1'b1, uls_pkg::OFS_INT_STS, 32'h1);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0);
    tx_run <= 1'b1;
    repeat (6) @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, uls_pkg::OFS_INT_MASK, 32'h0);
    repeat (50) @(negedge pclk);
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_fifo;
    apb(1'b1, A_CT, 32'h1);
    tx_run <= 1'b0;
    n0 = n_txwr;
    for (int i = 0; i < 3; i++) apb(1'b1, A_DT, 32'(8'h70 + i));
    ls(32'h00);
    chk(32'(n_txwr - n0), 32'h3);
    tx_run <= 1'b1;
    repeat (10) @(posedge pclk);
    ls(32'h00);
    repeat (150) @(posedge pclk);
    ls(32'h60);
  endtask

  task automatic t_rx;
    u_far.send(8'h41, 3'b001);
    u_far.send(8'h42, 3'b000);
    ls(32'he5);
    apb(1'b0, A_DT, 32'h0);
    chk(r, 32'h41);
    ls(32'h61);
    apb(1'b0, A_DT, 32'h0);
    ls(32'h60);
    apb(1'b1, A_CT, 32'h0);
    u_far.send(8'h51, 3'b000);
    u_far.send(8'h52, 3'b000);
    ls(32'h63);
    ls(32'h61);
    apb(1'b0, A_DT, 32'h0);
    chk(r, 32'h51);
    apb(1'b1, A_CT, 32'h1);
    u_far.line(1'b0);
    u_far.send(8'h00, 3'b100);
    u_far.send(8'h00, 3'b100);
    ls(32'hf1);
    apb(1'b0, A_DT, 32'h0);
    ls(32'h60);
    apb(1'b0, uls_pkg::OFS_INT_STS, 32'h0);
    chk(r, 32'hf);
    u_far.line(1'b1);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_modem();
    t_tx_char();
    t_irq();
    t_fifo();
    t_rx();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
endmodule

`default_nettype wire
